// [shared/ssp_pkg.sv]
// constants for the serial shift port control block
package ssp_pkg;
  // register byte offsets
  localparam logic [7:0] SSP_CTRL_OFS    = 8'hb8;
  localparam logic [7:0] SSP_PINPOS_OFS  = 8'hbc;
  localparam logic [7:0] SSP_CNT_OFS     = 8'hc0;
  localparam logic [7:0] SSP_DATA_OFS    = 8'hc4;
  localparam logic [7:0] SSP_PORT_OFS    = 8'hc8;
  localparam logic [7:0] SSP_IRQ_ST_OFS  = 8'hcc;
  localparam logic [7:0] SSP_IRQ_CLR_OFS = 8'hd0;
  localparam logic [7:0] SSP_IRQ_EN_OFS  = 8'hd4;
  // shift_port_control fields
  localparam int SSP_WM_LSB     = 4;
  localparam int SSP_CS_LSB     = 2;
  localparam int SSP_STROBE_BIT = 1;
  localparam int SSP_TOGGLE_BIT = 0;
  // port register fields
  localparam int SSP_PORT_DATA  = 0;
  localparam int SSP_PORT_CLK   = 1;
  localparam int SSP_DIR_DATA   = 2;
  localparam int SSP_DIR_CLK    = 3;
  // interrupt status fields
  localparam int SSP_IRQ_START  = 0;
  localparam int SSP_IRQ_OVF    = 1;
  // wire mode codes
  localparam logic [1:0] SSP_WM_OFF   = 2'h0;
  localparam logic [1:0] SSP_WM_THREE = 2'h1;
  localparam logic [1:0] SSP_WM_TWO   = 2'h2;
  localparam logic [1:0] SSP_WM_TWOH  = 2'h3;
  // clock source codes
  localparam logic [1:0] SSP_CS_SOFT  = 2'h0;
  localparam logic [1:0] SSP_CS_TIMER = 2'h1;
  // reset values
  localparam logic [7:0] SSP_RST_BYTE = 8'h00;
  localparam logic [3:0] SSP_RST_NIB  = 4'h0;
  localparam logic [1:0] SSP_RST_TWO  = 2'h0;
  // number of pin sets
  localparam int SSP_NSETS = 2;
endpackage

// [src/ssp_ctrl.sv]
// serial shift port control with wishbone registers
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RQ1 - two-wire data line pulled low when shift bit or port bit is zero
// RQ2 - two-wire clock line pulled low by port bit zero or start hold
// RQ3 - two-wire mode: start condition holds clock low until start flag is cleared
// RQ4 - two-wire mode disables pull-ups, inputs keep working
// RQ5 - mode 11 also holds clock low after overflow until flag cleared
// RQ6 - external clock: output latch updates on edge opposite to sampling
// RQ7 - strobe or timer clock: output latch is transparent
// RQ8 - clock source selects clocking of shift register and counter
// RQ9 - external: shift on chosen edge, counter on both edges
// RQ10 - external with strobe bit set: toggle write clocks the counter
// RQ11 - strobe write shifts and counts, shifting input sampled earlier
// RQ12 - strobe and toggle bits act on write and read as zero
// RQ13 - toggle write inverts clock port bit regardless of direction
// RQ14 - pin position bit picks default or alternate pin set
// RQ15 - pin position bits 7:1 read as zero
// RQ16 - mode 00 disables shift output, clock hold and start detector; pins follow port bits
// RQ17 - start is data falling while clock high, sets start flag
module ssp_ctrl #(
  parameter int DATA_W = 8,
  parameter int CNT_W  = 4
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [7:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  // timer compare match pulse
  input  wire logic                         tmr_match_i,
  // pin sets, index 0 default, 1 alternate
  input  wire logic [ssp_pkg::SSP_NSETS-1:0] serial_in_pin_i,
  output logic      [ssp_pkg::SSP_NSETS-1:0] serial_in_pin_o,
  output logic      [ssp_pkg::SSP_NSETS-1:0] serial_in_pin_oe_o,
  output logic      [ssp_pkg::SSP_NSETS-1:0] serial_in_pullup_o,
  output logic      [ssp_pkg::SSP_NSETS-1:0] serial_out_pin_o,
  output logic      [ssp_pkg::SSP_NSETS-1:0] serial_out_pin_oe_o,
  input  wire logic [ssp_pkg::SSP_NSETS-1:0] shift_clk_pin_i,
  output logic      [ssp_pkg::SSP_NSETS-1:0] shift_clk_pin_o,
  output logic      [ssp_pkg::SSP_NSETS-1:0] shift_clk_pin_oe_o,
  output logic      [ssp_pkg::SSP_NSETS-1:0] shift_clk_pullup_o,
  // interrupt
  output logic                              irq_o
);
  import ssp_pkg::*;

  if (DATA_W != 8 || CNT_W < 1 || CNT_W > 4) begin : g_chk
    $error("ssp_ctrl: DATA_W must be 8 and CNT_W 1..4");
  end

  // register state
  logic [1:0]        wire_mode_sel;
  logic [1:0]        clk_source_sel;
  logic              clk_strobe_bit;
  logic              pin_location_sel;
  logic [CNT_W-1:0]  cnt;
  logic [DATA_W-1:0] shreg;
  logic              port_data;
  logic              port_clk;
  logic              dir_data;
  logic              clk_pin_direction_bit;
  logic              start_cond_flag;
  logic              counter_overflow_flag;
  logic [1:0]        irq_en;

  // bus decode
  logic bus_req;
  logic bus_wr;
  logic wr_ctrl;
  logic strobe_wr;
  logic toggle_wr;
  logic clr_start;
  logic clr_ovf;
  assign bus_req   = wb_cyc_i && wb_stb_i;
  assign bus_wr    = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign wr_ctrl   = bus_wr && (wb_adr_i == SSP_CTRL_OFS);
  assign strobe_wr = wr_ctrl && wb_dat_i[SSP_STROBE_BIT];
  assign toggle_wr = wr_ctrl && wb_dat_i[SSP_TOGGLE_BIT];
  assign clr_start = bus_wr && (wb_adr_i == SSP_IRQ_CLR_OFS)
                     && wb_dat_i[SSP_IRQ_START];
  assign clr_ovf   = bus_wr && (wb_adr_i == SSP_IRQ_CLR_OFS)
                     && wb_dat_i[SSP_IRQ_OVF];

  // wishbone ack, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  // read data
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (wb_adr_i == SSP_CTRL_OFS) begin
      // see RQ12
      next_rdata[SSP_WM_LSB+1:SSP_WM_LSB] = wire_mode_sel;
      next_rdata[SSP_CS_LSB+1:SSP_CS_LSB] = clk_source_sel;
    end else if (wb_adr_i == SSP_PINPOS_OFS) begin
      next_rdata[0] = pin_location_sel; // see RQ15
    end else if (wb_adr_i == SSP_CNT_OFS) begin
      next_rdata[CNT_W-1:0] = cnt;
    end else if (wb_adr_i == SSP_DATA_OFS) begin
      next_rdata[DATA_W-1:0] = shreg;
    end else if (wb_adr_i == SSP_PORT_OFS) begin
      next_rdata[SSP_PORT_DATA] = port_data;
      next_rdata[SSP_PORT_CLK]  = port_clk;
      next_rdata[SSP_DIR_DATA]  = dir_data;
      next_rdata[SSP_DIR_CLK]   = clk_pin_direction_bit;
    end else if (wb_adr_i == SSP_IRQ_ST_OFS) begin
      next_rdata[SSP_IRQ_START] = start_cond_flag;
      next_rdata[SSP_IRQ_OVF]   = counter_overflow_flag;
    end else if (wb_adr_i == SSP_IRQ_EN_OFS) begin
      next_rdata[1:0] = irq_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  // control, pin position and interrupt enable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wire_mode_sel    <= SSP_RST_TWO;
      clk_source_sel   <= SSP_RST_TWO;
      clk_strobe_bit   <= 1'b0;
      pin_location_sel <= 1'b0;
      irq_en           <= SSP_RST_TWO;
    end else begin
      if (wr_ctrl) begin
        wire_mode_sel  <= wb_dat_i[SSP_WM_LSB+1:SSP_WM_LSB];
        clk_source_sel <= wb_dat_i[SSP_CS_LSB+1:SSP_CS_LSB];
        clk_strobe_bit <= wb_dat_i[SSP_STROBE_BIT];
      end
      if (bus_wr && wb_adr_i == SSP_PINPOS_OFS) begin
        pin_location_sel <= wb_dat_i[0];
      end
      if (bus_wr && wb_adr_i == SSP_IRQ_EN_OFS) begin
        irq_en <= wb_dat_i[1:0];
      end
    end
  end

  // port register, toggle inverts clock port bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_data             <= 1'b0;
      port_clk              <= 1'b0;
      dir_data              <= 1'b0;
      clk_pin_direction_bit <= 1'b0;
    end else if (bus_wr && wb_adr_i == SSP_PORT_OFS) begin
      port_data             <= wb_dat_i[SSP_PORT_DATA];
      port_clk              <= wb_dat_i[SSP_PORT_CLK];
      dir_data              <= wb_dat_i[SSP_DIR_DATA];
      clk_pin_direction_bit <= wb_dat_i[SSP_DIR_CLK];
    end else if (toggle_wr) begin
      port_clk <= !port_clk; // see RQ13
    end
  end

  // input synchronisers on selected pin set
  logic [2:0] din_sync;
  logic [2:0] cin_sync;
  logic       din;
  logic       cin;
  logic       din_q;
  logic       cin_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      din_sync <= 3'h7;
      cin_sync <= 3'h7;
      din      <= 1'b1;
      cin      <= 1'b1;
      din_q    <= 1'b1;
      cin_q    <= 1'b1;
    end else begin
      // see RQ14
      din_sync <= {din_sync[1:0], serial_in_pin_i[pin_location_sel]};
      cin_sync <= {cin_sync[1:0], shift_clk_pin_i[pin_location_sel]};
      if (din_sync[1] == din_sync[2]) begin
        din <= din_sync[2];
      end
      if (cin_sync[1] == cin_sync[2]) begin
        cin <= cin_sync[2];
      end
      din_q <= din;
      cin_q <= cin;
    end
  end

  // clock source selection
  logic ext_sel;
  logic cin_rise;
  logic cin_fall;
  logic sample_edge;
  logic launch_edge;
  logic shift_clk;
  logic cnt_clk;
  assign ext_sel     = clk_source_sel[1];
  assign cin_rise    = cin && !cin_q;
  assign cin_fall    = !cin && cin_q;
  // see RQ9
  assign sample_edge = clk_source_sel[0] ? cin_fall : cin_rise;
  assign launch_edge = clk_source_sel[0] ? cin_rise : cin_fall;
  always_comb begin
    shift_clk = 1'b0;
    cnt_clk   = 1'b0;
    if (ext_sel) begin
      shift_clk = sample_edge; // see RQ9
      // see RQ10
      cnt_clk   = clk_strobe_bit ? toggle_wr : (cin_rise || cin_fall);
    end else if (clk_source_sel == SSP_CS_TIMER) begin
      shift_clk = tmr_match_i; // see RQ8
      cnt_clk   = tmr_match_i;
    end else begin
      shift_clk = strobe_wr; // see RQ8
      cnt_clk   = strobe_wr;
    end
  end

  // shift register, strobe shifts in the earlier sample
  logic shift_in;
  assign shift_in = (ext_sel) ? din : din_q; // see RQ11
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shreg <= SSP_RST_BYTE;
    end else if (bus_wr && wb_adr_i == SSP_DATA_OFS) begin
      shreg <= wb_dat_i[DATA_W-1:0];
    end else if (shift_clk) begin
      shreg <= {shreg[DATA_W-2:0], shift_in}; // see RQ11
    end
  end

  // counter and overflow
  logic cnt_wrap;
  assign cnt_wrap = cnt_clk && (cnt == {CNT_W{1'b1}})
                    && !(bus_wr && wb_adr_i == SSP_CNT_OFS);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= SSP_RST_NIB[CNT_W-1:0];
    end else if (bus_wr && wb_adr_i == SSP_CNT_OFS) begin
      cnt <= wb_dat_i[CNT_W-1:0];
    end else if (cnt_clk) begin
      cnt <= cnt + 1'b1; // see RQ8
    end
  end

  // output latch
  logic out_latch;
  logic out_bit;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_latch <= 1'b0;
    end else if (launch_edge) begin
      out_latch <= shreg[DATA_W-1]; // see RQ6
    end
  end
  assign out_bit = ext_sel ? out_latch : shreg[DATA_W-1]; // see RQ7

  // start detector and flags, set wins over clear
  logic start_det;
  logic two_wire;
  assign two_wire  = wire_mode_sel[1];
  // see RQ17
  assign start_det = (wire_mode_sel != SSP_WM_OFF) && cin && cin_q
                     && din_q && !din;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_cond_flag       <= 1'b0;
      counter_overflow_flag <= 1'b0;
    end else begin
      if (start_det) begin
        start_cond_flag <= 1'b1; // see RQ17
      end else if (clr_start) begin
        start_cond_flag <= 1'b0;
      end
      if (cnt_wrap) begin
        counter_overflow_flag <= 1'b1;
      end else if (clr_ovf) begin
        counter_overflow_flag <= 1'b0;
      end
    end
  end

  // pin drive terms
  logic clk_hold;
  logic sda_low;
  logic scl_low;
  // see RQ3
  assign clk_hold = start_cond_flag
                    || (wire_mode_sel == SSP_WM_TWOH
                        && counter_overflow_flag); // see RQ5
  assign sda_low  = dir_data && (!out_bit || !port_data); // see RQ1
  assign scl_low  = clk_pin_direction_bit
                    && (!port_clk || clk_hold); // see RQ2

  // per pin set outputs, unselected set left undriven
  for (genvar g = 0; g < SSP_NSETS; g++) begin : g_set
    logic sel;
    assign sel = (pin_location_sel == 1'(g)); // see RQ14
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        serial_in_pin_o[g]     <= 1'b0;
        serial_in_pin_oe_o[g]  <= 1'b0;
        serial_in_pullup_o[g]  <= 1'b0;
        serial_out_pin_o[g]    <= 1'b0;
        serial_out_pin_oe_o[g] <= 1'b0;
        shift_clk_pin_o[g]     <= 1'b0;
        shift_clk_pin_oe_o[g]  <= 1'b0;
        shift_clk_pullup_o[g]  <= 1'b0;
      end else if (sel && two_wire) begin
        serial_in_pin_o[g]     <= 1'b0;
        serial_in_pin_oe_o[g]  <= sda_low; // see RQ1
        serial_in_pullup_o[g]  <= 1'b0; // see RQ4
        serial_out_pin_o[g]    <= 1'b0;
        serial_out_pin_oe_o[g] <= 1'b0;
        shift_clk_pin_o[g]     <= 1'b0;
        shift_clk_pin_oe_o[g]  <= scl_low; // see RQ2
        shift_clk_pullup_o[g]  <= 1'b0; // see RQ4
      end else if (sel) begin
        // see RQ16
        serial_in_pin_o[g]     <= 1'b0;
        serial_in_pin_oe_o[g]  <= 1'b0;
        serial_in_pullup_o[g]  <= 1'b0;
        serial_out_pin_o[g]    <= (wire_mode_sel == SSP_WM_THREE)
                                  ? out_bit : port_data;
        serial_out_pin_oe_o[g] <= dir_data;
        shift_clk_pin_o[g]     <= port_clk; // see RQ13
        shift_clk_pin_oe_o[g]  <= clk_pin_direction_bit;
        shift_clk_pullup_o[g]  <= !clk_pin_direction_bit && port_clk;
      end else begin
        serial_in_pin_o[g]     <= 1'b0;
        serial_in_pin_oe_o[g]  <= 1'b0;
        serial_in_pullup_o[g]  <= 1'b0;
        serial_out_pin_o[g]    <= 1'b0;
        serial_out_pin_oe_o[g] <= 1'b0;
        shift_clk_pin_o[g]     <= 1'b0;
        shift_clk_pin_oe_o[g]  <= 1'b0;
        shift_clk_pullup_o[g]  <= 1'b0;
      end
    end
  end

  // interrupt output
  assign irq_o = |({counter_overflow_flag, start_cond_flag} & irq_en);

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ctrl_read_zero_a: assert property ( // see RQ12
    (bus_req && !wb_we_i && wb_adr_i == SSP_CTRL_OFS && !wb_ack_o)
    |=> wb_dat_o[1:0] == 2'h0)
    else $error("strobe or toggle bit read back nonzero");

  pinpos_res_a: assert property ( // see RQ15
    (bus_req && !wb_we_i && wb_adr_i == SSP_PINPOS_OFS && !wb_ack_o)
    |=> wb_dat_o[7:1] == 7'h00)
    else $error("pin position reserved bits nonzero");

  start_hold_a: assert property ( // see RQ3
    (start_cond_flag && two_wire && clk_pin_direction_bit)
    |=> shift_clk_pin_oe_o[$past(pin_location_sel)])
    else $error("clock line not held after start");

  ovf_hold_a: assert property ( // see RQ5
    (counter_overflow_flag && wire_mode_sel == SSP_WM_TWOH
     && clk_pin_direction_bit) |=> shift_clk_pin_oe_o[$past(pin_location_sel)])
    else $error("clock line not held after overflow");

  sda_drive_a: assert property ( // see RQ1
    (two_wire && dir_data && !port_data)
    |=> serial_in_pin_oe_o[$past(pin_location_sel)])
    else $error("data line not pulled low");

  pullup_off_a: assert property ( // see RQ4
    two_wire |=> (serial_in_pullup_o == '0 && shift_clk_pullup_o == '0))
    else $error("pull-up on in two-wire mode");

  off_mode_a: assert property ( // see RQ16
    (wire_mode_sel == SSP_WM_OFF && !start_cond_flag)
    |=> !start_cond_flag)
    else $error("start detector active in mode 00");

  strobe_count_a: assert property ( // see RQ11
    (strobe_wr && clk_source_sel == SSP_CS_SOFT)
    |=> cnt == $past(cnt) + 1'b1 && shreg[0] == $past(din_q))
    else $error("strobe did not shift and count");

  toggle_inv_a: assert property ( // see RQ13
    (toggle_wr && !(bus_wr && wb_adr_i == SSP_PORT_OFS))
    |=> port_clk != $past(port_clk))
    else $error("toggle did not invert clock port bit");

  start_set_a: assert property ( // see RQ17
    start_det |=> start_cond_flag)
    else $error("start flag not set");

  ext_count_a: assert property ( // see RQ9
    (ext_sel && !clk_strobe_bit && (cin_rise || cin_fall)
     && !(bus_wr && wb_adr_i == SSP_CNT_OFS)) |=> cnt == $past(cnt) + 1'b1)
    else $error("external edge not counted");

endmodule
`default_nettype wire

// [verif/ssp_peer.sv]
// two-wire peer model pulling the data and clock lines of one pin set
`timescale 1ns/1ns
`default_nettype none
module ssp_peer (
  // open-drain pull requests, high pulls the line low
  output logic sda_low_o,
  output logic scl_low_o
);
  // half of the 48 ns link period
  localparam int HALF = 24;

  initial begin
    sda_low_o = 1'b0;
    scl_low_o = 1'b0;
  end

  // data falls while clock high, then clock falls, data released
  task automatic start_cond();
    #HALF sda_low_o = 1'b1;
    #HALF scl_low_o = 1'b1;
    #HALF sda_low_o = 1'b0;
    #HALF scl_low_o = 1'b0;
  endtask

  // clock pulses, line stands still outside them
  task automatic pulses(input int n);
    repeat (n) begin
      #HALF scl_low_o = 1'b1;
      #HALF scl_low_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [verif/ssp_ctrl_test.sv]
// self-checking bench of the serial shift port control block
`timescale 1ns/1ns
`default_nettype none
module ssp_ctrl_test;
  import ssp_pkg::*;
  localparam int LIMIT = 20000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        tmr_match_i = 1'b0;
  logic [1:0]  sda_w, scl_w, sda_o, sda_oe, pu_d, out_o, out_oe;
  logic [1:0]  scl_o, scl_oe, pu_c;
  logic        irq_o, peer_sda, peer_scl;
  logic        pos = 1'b0;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  initial forever #2 clk_i = ~clk_i;

  // wired-and of both parties, pull-up where nobody drives
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      sda_w[s] = (sda_oe[s] ? sda_o[s] : 1'b1) & ~(peer_sda & (pos == s[0]));
      scl_w[s] = (scl_oe[s] ? scl_o[s] : 1'b1) & ~(peer_scl & (pos == s[0]));
    end
  end

  ssp_ctrl i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tmr_match_i(tmr_match_i), .serial_in_pin_i(sda_w),
    .serial_in_pin_o(sda_o), .serial_in_pin_oe_o(sda_oe),
    .serial_in_pullup_o(pu_d), .serial_out_pin_o(out_o),
    .serial_out_pin_oe_o(out_oe), .shift_clk_pin_i(scl_w),
    .shift_clk_pin_o(scl_o), .shift_clk_pin_oe_o(scl_oe),
    .shift_clk_pullup_o(pu_c), .irq_o(irq_o)
  );

  ssp_peer i_peer (.sda_low_o(peer_sda), .scl_low_o(peer_scl));

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, {24'h0, e});
  endtask

  // pin outputs after sync and register delay
  task automatic pins(input logic [1:0] got, input logic [1:0] e);
    chk({30'h0, got}, {30'h0, e});
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SSP_PINPOS_OFS, 8'h00);
    rd(SSP_CTRL_OFS, 8'h00);
    rd(8'h00, 8'h00);
    wr(SSP_PINPOS_OFS, 8'hff);
    rd(SSP_PINPOS_OFS, 8'h01);
    wr(SSP_PINPOS_OFS, 8'h00);
    // soft strobe plus toggle in one write
    wr(SSP_CTRL_OFS, 8'h03);
    rd(SSP_CTRL_OFS, 8'h00);
    rd(SSP_CNT_OFS, 8'h01);
    rd(SSP_PORT_OFS, 8'h02);
    rd(SSP_DATA_OFS, 8'h01);
    wr(SSP_CTRL_OFS, 8'h00);
    rd(SSP_CNT_OFS, 8'h01);
    // wrap 15 to 0 sets overflow, raise, mask, clear
    wr(SSP_CNT_OFS, 8'h0f);
    wr(SSP_CTRL_OFS, 8'h02);
    rd(SSP_CNT_OFS, 8'h00);
    rd(SSP_IRQ_ST_OFS, 8'h02);
    wr(SSP_IRQ_EN_OFS, 8'h02);
    idle(1);
    chk({31'h0, irq_o}, 32'h1);
    wr(SSP_IRQ_EN_OFS, 8'h00);
    idle(1);
    chk({31'h0, irq_o}, 32'h0);
    wr(SSP_IRQ_CLR_OFS, 8'h02);
    rd(SSP_IRQ_ST_OFS, 8'h00);
    // timer compare clocking
    wr(SSP_CTRL_OFS, 8'h04);
    repeat (3) begin
      @(posedge clk_i) tmr_match_i <= 1'b1;
      @(posedge clk_i) tmr_match_i <= 1'b0;
    end
    rd(SSP_CNT_OFS, 8'h03);
    // external clock, both edges counted for either edge code
    for (int c = 2; c < 4; c++) begin
      wr(SSP_CNT_OFS, 8'h00);
      wr(SSP_CTRL_OFS, 8'(c << 2));
      i_peer.pulses(3);
      idle(10);
      rd(SSP_CNT_OFS, 8'h06);
    end
    // external with strobe bit: only toggle writes count
    wr(SSP_CNT_OFS, 8'h00);
    wr(SSP_CTRL_OFS, 8'h0a);
    i_peer.pulses(2);
    idle(10);
    wr(SSP_CTRL_OFS, 8'h0b);
    rd(SSP_CNT_OFS, 8'h01);
    // two-wire mode
    wr(SSP_DATA_OFS, 8'hff);
    wr(SSP_CTRL_OFS, 8'h20);
    wr(SSP_PORT_OFS, 8'h0f);
    idle(6);
    pins(scl_oe, 2'b00);
    pins(sda_oe, 2'b00);
    pins(pu_c | pu_d, 2'b00);
    pins(sda_o | scl_o, 2'b00);
    wr(SSP_PORT_OFS, 8'h0e);
    idle(6);
    pins(sda_oe, 2'b01);
    wr(SSP_PORT_OFS, 8'h0d);
    idle(6);
    pins(scl_oe, 2'b01);
    wr(SSP_PORT_OFS, 8'h0f);
    wr(SSP_DATA_OFS, 8'h7f);
    idle(6);
    pins(sda_oe, 2'b01);
    wr(SSP_DATA_OFS, 8'hff);
    wr(SSP_IRQ_CLR_OFS, 8'h01);
    rd(SSP_IRQ_ST_OFS, 8'h00);
    i_peer.start_cond();
    idle(10);
    rd(SSP_IRQ_ST_OFS, 8'h01);
    pins(scl_oe, 2'b01);
    wr(SSP_IRQ_EN_OFS, 8'h01);
    idle(1);
    chk({31'h0, irq_o}, 32'h1);
    wr(SSP_IRQ_CLR_OFS, 8'h01);
    idle(6);
    pins(scl_oe, 2'b00);
    chk({31'h0, irq_o}, 32'h0);
    // overflow holds the clock only in mode 11
    wr(SSP_CNT_OFS, 8'h0f);
    wr(SSP_CTRL_OFS, 8'h22);
    idle(6);
    pins(scl_oe, 2'b00);
    wr(SSP_IRQ_CLR_OFS, 8'h02);
    wr(SSP_CTRL_OFS, 8'h30);
    wr(SSP_CNT_OFS, 8'h0f);
    wr(SSP_CTRL_OFS, 8'h32);
    idle(6);
    pins(scl_oe, 2'b01);
    wr(SSP_IRQ_CLR_OFS, 8'h02);
    idle(6);
    pins(scl_oe, 2'b00);
    // alternate pin set
    wr(SSP_PINPOS_OFS, 8'h01);
    pos <= 1'b1;
    i_peer.start_cond();
    idle(10);
    rd(SSP_IRQ_ST_OFS, 8'h01);
    pins(scl_oe, 2'b10);
    wr(SSP_IRQ_CLR_OFS, 8'h01);
    wr(SSP_PINPOS_OFS, 8'h00);
    pos <= 1'b0;
    // three-wire: strobe output transparent, external output latched
    wr(SSP_CTRL_OFS, 8'h10);
    wr(SSP_PORT_OFS, 8'h04);
    wr(SSP_DATA_OFS, 8'h40);
    wr(SSP_CTRL_OFS, 8'h12);
    idle(3);
    pins(out_o, 2'b01);
    pins(out_oe, 2'b01);
    wr(SSP_CTRL_OFS, 8'h18);
    i_peer.pulses(1);
    idle(10);
    pins(out_o, 2'b01);
    i_peer.pulses(1);
    idle(10);
    pins(out_o, 2'b00);
    rd(SSP_DATA_OFS, 8'h07);
    // mode 00 ignores a start
    wr(SSP_CTRL_OFS, 8'h00);
    i_peer.start_cond();
    idle(10);
    rd(SSP_IRQ_ST_OFS, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
